// File: hw/aers_pkg.sv
// Package of register offsets, field layouts and carrier types for the amplifier event status block.
package aers_pkg;

    // Register offsets on the control bus.
    localparam logic [15:0] AERS_SUPPLY_RAW_ADDR = 16'h2003;
    localparam logic [15:0] AERS_BROWNOUT_RAW_ADDR = 16'h2004;
    localparam logic [15:0] AERS_STICKY_ADDR = 16'h2006;

    // Reset values of the three registers.
    localparam logic [7:0] AERS_SUPPLY_RAW_RESET = 8'h00;
    localparam logic [3:0] AERS_BROWNOUT_RAW_RESET = 4'h0;
    localparam logic [7:0] AERS_STICKY_RESET = 8'h00;

    // Answer to an address that this block does not hold.
    localparam logic [7:0] AERS_UNMAPPED_DATA = 8'h00;

    // Field positions of the supply, power and headroom live register.
    localparam int AERS_ANALOG_LOW_BIT = 7;
    localparam int AERS_CORE_LOW_BIT = 6;
    localparam int AERS_POWERUP_BIT = 5;
    localparam int AERS_POWERDOWN_BIT = 4;
    localparam int AERS_HV_LOW_BIT = 3;
    localparam int AERS_BATTERY_LOW_BIT = 2;
    localparam int AERS_HEADROOM_BEGIN_BIT = 1;
    localparam int AERS_HEADROOM_END_BIT = 0;

    // Field positions of the brownout engine live register.
    localparam int AERS_BROWNOUT_ZERO_BIT = 3;
    localparam int AERS_BROWNOUT_CHANGE_BIT = 2;
    localparam int AERS_BROWNOUT_BEGIN_BIT = 1;
    localparam int AERS_BROWNOUT_END_BIT = 0;

    // Field positions of the thermal and fault sticky register.
    localparam int AERS_OVERTEMP_BEGIN_BIT = 7;
    localparam int AERS_OVERTEMP_END_BIT = 6;
    localparam int AERS_WARN_ONE_BEGIN_BIT = 5;
    localparam int AERS_WARN_ONE_END_BIT = 4;
    localparam int AERS_FOLDBACK_BEGIN_BIT = 3;
    localparam int AERS_FOLDBACK_END_BIT = 2;
    localparam int AERS_FUSE_FAIL_BIT = 1;
    localparam int AERS_OVERCURRENT_BIT = 0;

    // Supply, power and headroom live indicators, packed in register order.
    typedef struct packed {
        logic analog_supply_low_live;
        logic core_supply_low_live;
        logic powerup_complete_live;
        logic powerdown_complete_live;
        logic hv_supply_low_live;
        logic battery_supply_low_live;
        logic headroom_track_begin_live;
        logic headroom_track_end_live;
    } aers_supply_t;

    // Brownout prevention engine live indicators, packed in register order.
    typedef struct packed {
        logic brownout_level_zero_live;
        logic brownout_level_change_live;
        logic brownout_begin_live;
        logic brownout_end_live;
    } aers_brownout_t;

    // Thermal and fault indicators; used for live inputs, clears and sticky flags alike.
    typedef struct packed {
        logic overtemp_off_begin;
        logic overtemp_off_end;
        logic temp_warn_one_begin;
        logic temp_warn_one_end;
        logic temp_foldback_begin;
        logic temp_foldback_end;
        logic fuse_load_fail;
        logic speaker_overcurrent;
    } aers_fault_t;

endpackage

// File: hw/aers_status.sv
// Live and sticky event status registers of the speaker amplifier, read over the control port.
`timescale 1ns/1ps
module aers_status
    import aers_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire aers_supply_t supply_live_in,
    input wire aers_brownout_t brownout_live_in,
    input wire aers_fault_t fault_live_in,
    input wire aers_fault_t sticky_clear_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_read_in,
    output logic [7:0] read_data_out,
    output logic read_valid_out,
    output aers_fault_t sticky_flags_out
);

    // Synchroniser stages for the supply, power and headroom indicators.
    // These come from analog comparators and sequencers that do not share
    // this clock, so each passes two flip-flops before any logic reads it.
    aers_supply_t supply_meta;
    aers_supply_t supply_sync;
    aers_supply_t next_supply_meta;
    aers_supply_t next_supply_sync;

    // Synchroniser stages for the brownout prevention engine indicators.
    aers_brownout_t brownout_meta;
    aers_brownout_t brownout_sync;
    aers_brownout_t next_brownout_meta;
    aers_brownout_t next_brownout_sync;

    // Synchroniser stages for the thermal and fault indicators, plus one
    // more stage that remembers the last synchronised value for edge detection.
    aers_fault_t fault_meta;
    aers_fault_t fault_sync;
    aers_fault_t fault_prev;
    aers_fault_t next_fault_meta;
    aers_fault_t next_fault_sync;
    aers_fault_t next_fault_prev;

    // Sticky flag state, its next value and the rising edges found this cycle.
    aers_fault_t sticky;
    aers_fault_t next_sticky;
    aers_fault_t fault_rise;

    // Next values of the output registers.
    logic [7:0] next_read_data;
    logic next_read_valid;
    aers_fault_t next_sticky_flags;

    // Rising edge detector on a synchronised fault vector.
    // Both arguments come from behind the second synchroniser stage, never
    // from the first, so a metastable sample cannot produce a false edge.
    function automatic aers_fault_t aers_rising(
        input aers_fault_t now_value,
        input aers_fault_t last_value
    );
        return now_value & ~last_value;
    endfunction

    // Sticky update: a clear drops a flag and a rising edge sets it.
    // The set is applied last, so an event that lands in the very cycle of
    // its clear is kept; losing a thermal or fault event is the worse hazard.
    function automatic aers_fault_t aers_sticky_update(
        input aers_fault_t flags,
        input aers_fault_t clear,
        input aers_fault_t rise
    );
        return (flags & ~clear) | rise;
    endfunction

    // Read multiplexer over the three held registers.
    // An address that this block does not hold answers with the unmapped
    // value, so a host scanning the map never sees stale data from here.
    function automatic logic [7:0] aers_read_mux(
        input logic [15:0] addr,
        input aers_supply_t supply,
        input aers_brownout_t brownout,
        input aers_fault_t flags
    );
        logic [7:0] value;
        value = AERS_UNMAPPED_DATA;
        unique case (addr)
            AERS_SUPPLY_RAW_ADDR: begin
                value = supply;
            end
            AERS_BROWNOUT_RAW_ADDR: begin
                value = {4'h0, brownout};
            end
            AERS_STICKY_ADDR: begin
                value = flags;
            end
            default: begin
                value = AERS_UNMAPPED_DATA;
            end
        endcase
        return value;
    endfunction

    // Next values of the supply synchroniser; the first stage feeds only the second.
    always_comb begin
        next_supply_meta = supply_live_in;
        next_supply_sync = supply_meta;
    end

    // Supply synchroniser registers.
    // Reset clears both stages, so the live register reads its reset value
    // until the second edge after release, one edge after the indicators are sampled again.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            supply_meta <= AERS_SUPPLY_RAW_RESET;
            supply_sync <= AERS_SUPPLY_RAW_RESET;
        end else begin
            supply_meta <= next_supply_meta;
            supply_sync <= next_supply_sync;
        end
    end

    // Next values of the brownout synchroniser; the first stage feeds only the second.
    always_comb begin
        next_brownout_meta = brownout_live_in;
        next_brownout_sync = brownout_meta;
    end

    // Brownout synchroniser registers.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            brownout_meta <= AERS_BROWNOUT_RAW_RESET;
            brownout_sync <= AERS_BROWNOUT_RAW_RESET;
        end else begin
            brownout_meta <= next_brownout_meta;
            brownout_sync <= next_brownout_sync;
        end
    end

    // Next values of the fault synchroniser and its history stage.
    // The history stage reads only the second stage, never the first.
    always_comb begin
        next_fault_meta = fault_live_in;
        next_fault_sync = fault_meta;
        next_fault_prev = fault_sync;
    end

    // Fault synchroniser registers.
    // The history resets low, so an indicator that is already high while
    // reset is held is seen as a rising edge a few cycles after release.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fault_meta <= AERS_STICKY_RESET;
            fault_sync <= AERS_STICKY_RESET;
            fault_prev <= AERS_STICKY_RESET;
        end else begin
            fault_meta <= next_fault_meta;
            fault_sync <= next_fault_sync;
            fault_prev <= next_fault_prev;
        end
    end

    // Sticky flags: a rising edge sets, a clear pulse drops, set wins a tie.
    // No mask exists anywhere on this path, so every edge is recorded.
    always_comb begin
        fault_rise = aers_rising(fault_sync, fault_prev);
        next_sticky = aers_sticky_update(sticky, sticky_clear_in, fault_rise);
    end

    // Sticky flag register; a falling indicator never clears a flag.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sticky <= AERS_STICKY_RESET;
        end else begin
            sticky <= next_sticky;
        end
    end

    // Read decode; data appears one cycle after the read strobe.
    // The sticky register is read through its next value, so the byte read
    // and the flag output always agree, even when a set or clear lands in
    // the read cycle itself.
    always_comb begin
        next_read_valid = reg_read_in;
        next_read_data = AERS_UNMAPPED_DATA;
        next_sticky_flags = next_sticky;
        if (reg_read_in) begin
            next_read_data = aers_read_mux(reg_addr_in, supply_sync, brownout_sync, next_sticky);
        end
    end

    // Output registers, so every output comes straight from a flip-flop.
    // Between reads the data output returns to zero, which keeps the port
    // quiet and makes a missing strobe easy to spot.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            read_data_out <= AERS_UNMAPPED_DATA;
            read_valid_out <= 1'b0;
            sticky_flags_out <= AERS_STICKY_RESET;
        end else begin
            read_data_out <= next_read_data;
            read_valid_out <= next_read_valid;
            sticky_flags_out <= next_sticky_flags;
        end
    end

endmodule // aers_status

// File: tb/aers_status_assertions.sv
// Checker of the event status read port and sticky flags.
`timescale 1ns/1ps
module aers_status_assertions
    import aers_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire aers_fault_t fault_live_in,
    input wire aers_fault_t sticky_clear_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_read_in,
    input wire logic [7:0] read_data_out,
    input wire logic read_valid_out,
    input wire aers_fault_t sticky_flags_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // Flags that no clear touches this cycle must survive it.
    logic [7:0] held;
    assign held = sticky_flags_out & ~sticky_clear_in;
    sequence quiet_raw;
        $stable(fault_live_in)[*4];
    endsequence
    sequence fuse_rise;
        $rose(fault_live_in[1]) ##1 (fault_live_in[1] && !sticky_clear_in[1])[*3];
    endsequence
    valid_pulse_a: assert property (reg_read_in |=> read_valid_out) else $error("no answer");
    idle_zero_a: assert property (!reg_read_in |=> !read_valid_out && read_data_out == 8'h00) else $error("idle");
    sticky_read_a: assert property (reg_read_in && reg_addr_in == AERS_STICKY_ADDR |=>
        read_data_out == sticky_flags_out) else $error("sticky read");
    unmapped_zero_a: assert property (reg_read_in && reg_addr_in == 16'h2005 |=> read_data_out == 8'h00)
        else $error("unmapped");
    brownout_top_a: assert property (reg_read_in && reg_addr_in == AERS_BROWNOUT_RAW_ADDR |=>
        read_data_out[7:4] == 4'h0) else $error("brownout top");
    flag_hold_a: assert property (1'b1 |=> ($past(held) & ~sticky_flags_out) == 8'h00) else $error("hold");
    clear_wins_a: assert property (quiet_raw ##0 sticky_clear_in != 8'h00 |=>
        (sticky_flags_out & $past(sticky_clear_in)) == 8'h00) else $error("clear");
    fuse_set_a: assert property (fuse_rise |=> sticky_flags_out[1]) else $error("fuse set");
endmodule // aers_status_assertions
bind aers_status aers_status_assertions chk (.clk_in(clk_in), .rst_in(rst_in), .fault_live_in(fault_live_in),
    .sticky_clear_in(sticky_clear_in), .reg_addr_in(reg_addr_in), .reg_read_in(reg_read_in),
    .read_data_out(read_data_out), .read_valid_out(read_valid_out), .sticky_flags_out(sticky_flags_out));

// File: tb/aers_host_model.sv
// Host model that reads status registers and pulses sticky clears.
`timescale 1ns/1ps
module aers_host_model
    import aers_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] read_data_in,
    input wire logic read_valid_in,
    output logic [15:0] reg_addr_out,
    output logic reg_read_out,
    output aers_fault_t sticky_clear_out
);
    // Requests move at the falling edge so each is held across a rising edge.
    initial begin
        reg_addr_out = 16'h0000;
        reg_read_out = 1'b0;
        sticky_clear_out = '0;
    end
    task automatic rd(input logic [15:0] a, output logic [8:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        reg_read_out = 1'b1;
        @(negedge clk_in);
        reg_read_out = 1'b0;
        reg_addr_out = ~a;
        d = {read_valid_in, read_data_in};
    endtask
    task automatic clr(input aers_fault_t m);
        @(negedge clk_in);
        sticky_clear_out = m;
        @(negedge clk_in);
        sticky_clear_out = '0;
    endtask
endmodule // aers_host_model

// File: tb/test_aers_status.sv
// Self-checking test of the amplifier event status registers.
`timescale 1ns/1ps
module test_aers_status;
    import aers_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    aers_supply_t sup = '0;
    aers_brownout_t bro = '0;
    aers_fault_t flt = '0;
    aers_fault_t clr, flags;
    logic [15:0] addr;
    logic rd, vld;
    logic [7:0] data;
    logic [8:0] got;
    logic [7:0] pat [2] = '{8'hA5, 8'h5A};
    int miscompares = 0;
    int tests_run = 0;
    always #25 clk_in = ~clk_in;
    aers_status dut (.clk_in(clk_in), .rst_in(rst_in), .supply_live_in(sup), .brownout_live_in(bro),
        .fault_live_in(flt), .sticky_clear_in(clr), .reg_addr_in(addr), .reg_read_in(rd),
        .read_data_out(data), .read_valid_out(vld), .sticky_flags_out(flags));
    aers_host_model host (.clk_in(clk_in), .read_data_in(data), .read_valid_in(vld), .reg_addr_out(addr),
        .reg_read_out(rd), .sticky_clear_out(clr));
    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [15:0] a, input logic [7:0] e);
        host.rd(a, got);
        chk(n, {1'b1, e}, got);
    endtask
    // Live inputs pass two sync stages, so wait before reading them back.
    task automatic st();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #40000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        rchk("raw reset", AERS_SUPPLY_RAW_ADDR, AERS_SUPPLY_RAW_RESET);
        rchk("unmapped", 16'h2005, AERS_UNMAPPED_DATA);
        foreach (pat[i]) begin
            sup = pat[i];
            bro = pat[i][3:0];
            st();
            rchk("supply", AERS_SUPPLY_RAW_ADDR, pat[i]);
            rchk("brownout", AERS_BROWNOUT_RAW_ADDR, {4'h0, pat[i][3:0]});
        end
        for (int i = 0; i < 8; i++) begin
            flt = aers_fault_t'(8'h01 << i);
            st();
            flt = '0;
            st();
            rchk("sticky", AERS_STICKY_ADDR, 8'h01 << i);
            chk("flags", {1'b0, 8'h01 << i}, {1'b0, flags});
            host.clr(aers_fault_t'(8'h01 << i));
            rchk("cleared", AERS_STICKY_ADDR, 8'h00);
        end
        flt = '1;
        st();
        host.clr('1);
        rchk("no rise", AERS_STICKY_ADDR, 8'h00);
        test_done();
    end
endmodule // test_aers_status
